//--- bench/dhp_core_model.sv
// register file model standing behind the host port
`timescale 1ns/100ps
`default_nettype none
module dhp_core_model (
	// clock
	input wire logic clk,
	// write side
	input wire logic regWrValid,
	output logic regWrReady,
	input wire dhp_pkg::dhp_wr_type regWr,
	input wire logic stall,
	// read side
	input wire logic regRdStrobe,
	input wire logic [5:0] regRdAddr,
	output logic [7:0] regRdData
);
	logic [7:0] mem [64];
	int wrCount = 0;
	// ready drops while the bench holds the core off
	assign regWrReady = !stall;
	// store each accepted write
	always @(posedge clk) begin
		if (regWrValid && regWrReady) begin
			mem[regWr.addr] <= regWr.data;
			wrCount <= wrCount + 1;
		end
	end
	// unselected read data is inverted, never the real value
	assign regRdData = regRdStrobe ? mem[regRdAddr] : ~mem[regRdAddr];
endmodule : dhp_core_model
`default_nettype wire

//--- bench/tb_top.sv
// self-checking bench for the disk controller host port
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin \
	comparisons++; \
	if ((got) !== (ex)) begin \
		num_errors++; \
		$display("CHECK FAILED %s expected %h seen %h", nm, ex, got); \
	end \
end
module tb_top;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic hostWr = 1'b0;
	logic hostRd = 1'b0;
	logic sel = 1'b0;
	logic stall = 1'b0;
	logic [7:0] hostDataIn = 8'h00;
	logic [6:0] pins = 7'h00;
	logic ce = 1'b1;
	logic rclk = 1'b0;
	logic rdd = 1'b0;
	logic slowReq, fastReq;
	logic [7:0] hostDataOut, regRdData;
	logic regWrValid, regWrReady, regRdStrobe, diskDataSel;
	logic [5:0] regRdAddr;
	dhp_pkg::dhp_wr_type regWr;
	int num_errors = 0;
	int comparisons = 0;
	int cycles = 0;
	// design under test
	dhp_host_port DUT (.clk(clk), .nrst(nrst), .ce(ce), .hostWr(hostWr),
		.hostRd(hostRd), .portSelectLine(sel), .hostDataIn(hostDataIn),
		.hostDataOut(hostDataOut), .regWrValid(regWrValid),
		.regWrReady(regWrReady), .regWr(regWr), .regRdStrobe(regRdStrobe),
		.regRdAddr(regRdAddr), .regRdData(regRdData),
		.diskDataSel(diskDataSel), .diskOpActive(pins[6]),
		.writeGate(pins[5]), .dataRequest(pins[4]), .dataAvailable(pins[3]),
		.errorBits({pins[0], 7'h00}), .seekCompleteIn(pins[2]),
		.trackZeroIn(pins[1]), .recoveredReadClockIn(rclk),
		.readDataDelayed(rdd), .slowDownRequest(slowReq),
		.speedUpRequest(fastReq));
	// core register file
	dhp_core_model core (.clk(clk), .regWrValid(regWrValid),
		.regWrReady(regWrReady), .regWr(regWr), .stall(stall),
		.regRdStrobe(regRdStrobe), .regRdAddr(regRdAddr),
		.regRdData(regRdData));
	// 10 MHz clock
	always #50 clk = ~clk;
	// hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			num_errors++;
			print_verdict();
		end
	end
	// one host access, then one idle edge before the next strobe
	task automatic acc(input logic wr, input logic s, input logic [7:0] d);
		hostWr = wr;
		hostRd = !wr;
		sel = s;
		hostDataIn = d;
		@(negedge clk);
		hostWr = 1'b0;
		hostRd = 1'b0;
		@(negedge clk);
	endtask : acc
	// read access, data registered by the taking edge
	task automatic rd(input logic s, output logic [7:0] v);
		acc(1'b0, s, 8'h00);
		v = hostDataOut;
	endtask : rd
	// each status source alone, then all quiet
	task automatic t_status;
		logic [7:0] v;
		logic [7:0] want;
		for (int i = 0; i < 8; i++) begin
			pins = (i < 7) ? (7'h40 >> i) : 7'h00;
			repeat (6) @(negedge clk);
			rd(1'b0, v);
			want = (i == 0) ? 8'hC0 : (8'h40 >> i);
			`CHK("status", want, v)
		end
	endtask : t_status
	// writes and reads walk the pointer upward
	task automatic t_autoinc;
		logic [7:0] v;
		acc(1'b1, 1'b0, 8'h81);
		acc(1'b1, 1'b1, 8'h5A);
		acc(1'b1, 1'b1, 8'hC3);
		repeat (4) @(negedge clk);
		acc(1'b1, 1'b0, 8'h81);
		rd(1'b1, v);
		`CHK("first byte", 8'h5A, v)
		rd(1'b1, v);
		`CHK("second byte", 8'hC3, v)
		`CHK("pointer after reads", 6'h03, regRdAddr)
	endtask : t_autoinc
	// step and disk data places hold the pointer
	task automatic t_noinc;
		logic [7:0] v;
		acc(1'b1, 1'b0, 8'h9F);
		acc(1'b1, 1'b1, 8'h11);
		acc(1'b1, 1'b1, 8'h22);
		repeat (4) @(negedge clk);
		`CHK("step reg", 8'h22, core.mem[31])
		`CHK("pointer at step", 6'h1F, regRdAddr)
		acc(1'b1, 1'b0, 8'hC0);
		acc(1'b1, 1'b1, 8'h33);
		rd(1'b1, v);
		`CHK("disk data byte", 8'h33, v)
		`CHK("disk data selected", 1'b1, diskDataSel)
		`CHK("pointer at data", 6'h00, regRdAddr)
	endtask : t_noinc
	// queue fills while stalled, busy shows, then drains
	task automatic t_fifo;
		logic [7:0] v;
		int base;
		base = core.wrCount;
		stall = 1'b1;
		repeat (17) acc(1'b1, 1'b1, 8'h44);
		rd(1'b0, v);
		`CHK("busy while queued", 1'b1, v[7])
		stall = 1'b0;
		repeat (24) @(negedge clk);
		`CHK("writes kept", base + 16, core.wrCount)
		rd(1'b0, v);
		`CHK("idle status", 8'h00, v)
	endtask : t_fifo
	// a new command clears the error summary
	task automatic t_errclr;
		logic [7:0] v;
		pins = 7'h01;
		repeat (4) @(negedge clk);
		rd(1'b0, v);
		`CHK("error set", 8'h01, v)
		acc(1'b1, 1'b0, 8'h3F);
		acc(1'b1, 1'b1, 8'h00);
		repeat (4) @(negedge clk);
		rd(1'b0, v);
		`CHK("error after command", 1'b0, v[0])
		pins = 7'h00;
	endtask : t_errclr
	// phase detector: late clock, locked, early clock, quiet
	task automatic t_phase;
		rdd = 1'b1;
		repeat (5) @(negedge clk);
		`CHK("speed_up_request", 2'b01, {slowReq, fastReq})
		rclk = 1'b1;
		repeat (5) @(negedge clk);
		`CHK("locked", 2'b00, {slowReq, fastReq})
		rdd = 1'b0;
		repeat (5) @(negedge clk);
		`CHK("slow_down_request", 2'b10, {slowReq, fastReq})
		rclk = 1'b0;
		repeat (5) @(negedge clk);
		`CHK("quiet", 2'b00, {slowReq, fastReq})
	endtask : t_phase
	// enable low ignores a pointer write
	task automatic t_freeze;
		acc(1'b1, 1'b0, 8'h85);
		ce = 1'b0;
		acc(1'b1, 1'b0, 8'h8A);
		`CHK("frozen pointer", 6'h05, regRdAddr)
		ce = 1'b1;
		acc(1'b1, 1'b0, 8'h8A);
		`CHK("pointer after enable", 6'h0A, regRdAddr)
	endtask : t_freeze
	// verdict and end of run
	task automatic print_verdict;
		if (num_errors == 0 && comparisons > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : print_verdict
	// main sequence
	initial begin
		repeat (10) @(negedge clk);
		nrst = 1'b1;
		repeat (3) @(negedge clk);
		t_status();
		t_autoinc();
		t_noinc();
		t_fifo();
		t_errclr();
		t_phase();
		t_freeze();
		print_verdict();
	end
endmodule : tb_top
`default_nettype wire

//--- verilog/dhp_fifo.sv
// parameterised valid/ready fifo
`timescale 1ns/100ps
`default_nettype none
module dhp_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	// clock and reset
	input wire logic clk,
	input wire logic rstN,
	input wire logic ce,
	// fill side
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	// drain side
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wrPtr_q;
	logic [AW-1:0] rdPtr_q;
	logic [AW:0] count_q;
	logic push;
	logic pop;
	// flags from occupancy
	assign inReady = (count_q != (AW+1)'(DEPTH));
	assign outValid = (count_q != '0);
	assign push = inValid && inReady && ce;
	assign pop = outValid && outReady && ce;
	assign outData = mem[rdPtr_q];
	// storage write
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wrPtr_q] <= inData;
		end
	end
	// pointers and count
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
			count_q <= '0;
		end else begin
			if (push) begin
				wrPtr_q <= wrPtr_q + 1'b1;
			end
			if (pop) begin
				rdPtr_q <= rdPtr_q + 1'b1;
			end
			if (push && !pop) begin
				count_q <= count_q + 1'b1;
			end else if (pop && !push) begin
				count_q <= count_q - 1'b1;
			end
		end
	end
endmodule : dhp_fifo
`default_nettype wire

//--- verilog/dhp_host_port.sv
// host register port with status, pointer, write fifo and phase detector
`timescale 1ns/100ps
`default_nettype none
module dhp_host_port #(
	parameter int ERR_WIDTH = 8
) (
	// clock, reset, enable
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	// host bus
	input wire logic hostWr,
	input wire logic hostRd,
	input wire logic portSelectLine,
	input wire logic [7:0] hostDataIn,
	output logic [7:0] hostDataOut,
	// register file side
	output logic regWrValid,
	input wire logic regWrReady,
	output dhp_pkg::dhp_wr_type regWr,
	output logic regRdStrobe,
	output logic [5:0] regRdAddr,
	input wire logic [7:0] regRdData,
	output logic diskDataSel,
	// core status
	input wire logic diskOpActive,
	input wire logic writeGate,
	input wire logic dataRequest,
	input wire logic dataAvailable,
	input wire logic [ERR_WIDTH-1:0] errorBits,
	// drive pins
	input wire logic seekCompleteIn,
	input wire logic trackZeroIn,
	// phase detector
	input wire logic recoveredReadClockIn,
	input wire logic readDataDelayed,
	output logic slowDownRequest,
	output logic speedUpRequest
);
	logic [1:0] rstSync_q;
	logic rstN;
	logic [2:0] seekSync_q;
	logic [2:0] trk0Sync_q;
	logic [2:0] rclkSync_q;
	logic [2:0] rdd_q;
	logic seekLvl_q;
	logic trk0Lvl_q;
	logic [7:0] ptr_q;
	logic errMask_q;
	dhp_pkg::dhp_state_type state_q;
	logic accessDone;
	logic advance;
	logic fifoInReady;
	logic fifoPush;
	logic [7:0] status;
	logic errSummary;
	// reset release through two stages
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rstSync_q <= 2'h0;
		end else begin
			rstSync_q <= {rstSync_q[0], 1'b1};
		end
	end
	assign rstN = rstSync_q[1];
	// pin synchronisers, three stages
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			seekSync_q <= 3'h0;
			trk0Sync_q <= 3'h0;
			rclkSync_q <= 3'h0;
			rdd_q <= 3'h0;
		end else if (ce) begin
			seekSync_q <= {seekSync_q[1:0], seekCompleteIn};
			trk0Sync_q <= {trk0Sync_q[1:0], trackZeroIn};
			rclkSync_q <= {rclkSync_q[1:0], recoveredReadClockIn};
			rdd_q <= {rdd_q[1:0], readDataDelayed};
		end
	end
	// accept level once stages two and three agree
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			seekLvl_q <= 1'b0;
			trk0Lvl_q <= 1'b0;
		end else if (ce) begin
			if (seekSync_q[1] == seekSync_q[2]) begin
				seekLvl_q <= seekSync_q[2];
			end
			if (trk0Sync_q[1] == trk0Sync_q[2]) begin
				trk0Lvl_q <= trk0Sync_q[2];
			end
		end
	end
	// phase compare: data edge before clock edge means clock is late
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			slowDownRequest <= 1'b0;
			speedUpRequest <= 1'b0;
		end else if (ce) begin
			speedUpRequest <= rdd_q[2] && !rclkSync_q[2];
			slowDownRequest <= rclkSync_q[2] && !rdd_q[2];
		end
	end
	// writes to data register go through the fifo
	assign fifoPush = ce && hostWr && portSelectLine;
	dhp_fifo #(
		.WIDTH($bits(dhp_pkg::dhp_wr_type)),
		.DEPTH(dhp_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.rstN(rstN),
		.ce(ce),
		.inValid(fifoPush),
		.inReady(fifoInReady),
		.inData({hostDataIn, ptr_q[5:0]}),
		.outValid(regWrValid),
		.outReady(regWrReady),
		.outData(regWr)
	);
	// read path to the pointed register
	assign regRdStrobe = ce && hostRd && portSelectLine;
	assign regRdAddr = ptr_q[5:0];
	assign diskDataSel = ptr_q[dhp_pkg::PTR_DATA_BIT];
	// advance only on non-data accesses with auto-inc, except writes to step
	assign accessDone = (regRdStrobe || (fifoPush && fifoInReady));
	assign advance = accessDone && ptr_q[dhp_pkg::PTR_INC_BIT]
		&& !ptr_q[dhp_pkg::PTR_DATA_BIT]
		&& !(fifoPush && ptr_q[5:0] == dhp_pkg::REG_STEP);
	// register pointer
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			ptr_q <= dhp_pkg::PTR_RESET;
		end else if (ce) begin
			if (hostWr && !portSelectLine) begin
				ptr_q <= hostDataIn;
			end else if (advance) begin
				ptr_q[5:0] <= ptr_q[5:0] + 6'h01;
			end
		end
	end
	// busy sequencer: increment and byte processing
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			state_q <= dhp_pkg::IDLE;
		end else if (ce) begin
			case (state_q)
				dhp_pkg::IDLE: begin
					if (advance) begin
						state_q <= dhp_pkg::INCR;
					end else if (fifoPush) begin
						state_q <= dhp_pkg::BUSY;
					end
				end
				dhp_pkg::INCR: begin
					state_q <= dhp_pkg::BUSY;
				end
				default: begin
					if (advance) begin
						state_q <= dhp_pkg::INCR;
					end else if (!regWrValid && !fifoPush) begin
						state_q <= dhp_pkg::IDLE;
					end
				end
			endcase
		end
	end
	// error summary cleared by a disk op command, stays clear until all error bits drop
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			errMask_q <= 1'b0;
		end else if (ce) begin
			if (fifoPush && ptr_q[5:0] == dhp_pkg::REG_DISK_OP
				&& !ptr_q[dhp_pkg::PTR_DATA_BIT]) begin
				errMask_q <= 1'b1;
			end else if (errorBits == '0) begin
				errMask_q <= 1'b0;
			end
		end
	end
	assign errSummary = (|errorBits) && !errMask_q;
	// status byte assembly
	always_comb begin
		status = 8'h00;
		status[dhp_pkg::ST_BUSY] = diskOpActive || regWrValid
			|| (state_q != dhp_pkg::IDLE);
		status[dhp_pkg::ST_OP] = diskOpActive;
		status[dhp_pkg::ST_WGATE] = writeGate;
		status[dhp_pkg::ST_DREQ] = dataRequest;
		status[dhp_pkg::ST_DAVAIL] = dataAvailable;
		status[dhp_pkg::ST_SEEK] = seekLvl_q;
		status[dhp_pkg::ST_TRK0] = trk0Lvl_q;
		status[dhp_pkg::ST_ERR] = errSummary;
	end
	// registered read data
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			hostDataOut <= 8'h00;
		end else if (ce && hostRd) begin
			hostDataOut <= portSelectLine ? regRdData : status;
		end
	end
	// checks
	property p_ptrLoad;
		@(posedge clk) disable iff (!rstN)
		(ce && hostWr && !portSelectLine) |=> ptr_q == $past(hostDataIn);
	endproperty
	a_ptrLoad: assert property (p_ptrLoad) else $error("pointer not loaded");
	property p_inc;
		@(posedge clk) disable iff (!rstN)
		(ce && advance && !(hostWr && !portSelectLine))
		|=> ptr_q[5:0] == $past(ptr_q[5:0]) + 6'h01;
	endproperty
	a_inc: assert property (p_inc) else $error("pointer did not advance");
	property p_noStep;
		@(posedge clk) disable iff (!rstN)
		(ce && fifoPush && ptr_q[5:0] == dhp_pkg::REG_STEP && !hostRd)
		|=> $stable(ptr_q);
	endproperty
	a_noStep: assert property (p_noStep) else $error("step advanced");
	property p_noData;
		@(posedge clk) disable iff (!rstN)
		(ce && portSelectLine && ptr_q[dhp_pkg::PTR_DATA_BIT]
		&& !(hostWr && !portSelectLine)) |=> $stable(ptr_q);
	endproperty
	a_noData: assert property (p_noData) else $error("data advanced");
	property p_busy;
		@(posedge clk) disable iff (!rstN)
		(diskOpActive || regWrValid) |-> status[dhp_pkg::ST_BUSY];
	endproperty
	a_busy: assert property (p_busy) else $error("busy low");
	property p_incBusy;
		@(posedge clk) disable iff (!rstN)
		(ce && advance) |=> status[dhp_pkg::ST_BUSY];
	endproperty
	a_incBusy: assert property (p_incBusy) else $error("no busy on inc");
	property p_op;
		@(posedge clk) disable iff (!rstN)
		status[dhp_pkg::ST_OP] == diskOpActive;
	endproperty
	a_op: assert property (p_op) else $error("op bit wrong");
	property p_wg;
		@(posedge clk) disable iff (!rstN)
		status[dhp_pkg::ST_WGATE] == writeGate;
	endproperty
	a_wg: assert property (p_wg) else $error("write gate bit wrong");
	property p_err;
		@(posedge clk) disable iff (!rstN)
		(errorBits == '0) |-> !status[dhp_pkg::ST_ERR];
	endproperty
	a_err: assert property (p_err) else $error("error without cause");
	property p_errClr;
		@(posedge clk) disable iff (!rstN)
		(ce && fifoPush && ptr_q == {2'b00, dhp_pkg::REG_DISK_OP})
		|=> !status[dhp_pkg::ST_ERR];
	endproperty
	a_errClr: assert property (p_errClr) else $error("error not cleared");
	property p_stRead;
		@(posedge clk) disable iff (!rstN)
		(ce && hostRd && !portSelectLine) |=> hostDataOut == $past(status);
	endproperty
	a_stRead: assert property (p_stRead) else $error("status read wrong");
	// status mirrors of the core handshakes
	property p_dreq;
		@(posedge clk) disable iff (!rstN)
		status[dhp_pkg::ST_DREQ] == dataRequest;
	endproperty
	a_dreq: assert property (p_dreq) else $error("request bit wrong");
	property p_davail;
		@(posedge clk) disable iff (!rstN)
		status[dhp_pkg::ST_DAVAIL] == dataAvailable;
	endproperty
	a_davail: assert property (p_davail) else $error("avail bit wrong");
	// pin levels reach status once two stages agree
	property p_seek;
		@(posedge clk) disable iff (!rstN)
		(ce && seekSync_q[1] == seekSync_q[2])
		|=> status[dhp_pkg::ST_SEEK] == $past(seekSync_q[2]);
	endproperty
	a_seek: assert property (p_seek) else $error("seek bit wrong");
	property p_trk0;
		@(posedge clk) disable iff (!rstN)
		(ce && trk0Sync_q[1] == trk0Sync_q[2])
		|=> status[dhp_pkg::ST_TRK0] == $past(trk0Sync_q[2]);
	endproperty
	a_trk0: assert property (p_trk0) else $error("track bit wrong");
	// phase requests follow the synchronised levels
	property p_fast;
		@(posedge clk) disable iff (!rstN)
		(ce && rdd_q[2] && !rclkSync_q[2]) |=> speedUpRequest;
	endproperty
	a_fast: assert property (p_fast) else $error("no speed_up_request request");
	property p_slow;
		@(posedge clk) disable iff (!rstN)
		(ce && rclkSync_q[2] && !rdd_q[2]) |=> slowDownRequest;
	endproperty
	a_slow: assert property (p_slow) else $error("no slow_down_request request");
	property p_oneDir;
		@(posedge clk) disable iff (!rstN)
		!(slowDownRequest && speedUpRequest);
	endproperty
	a_oneDir: assert property (p_oneDir) else $error("both requests");
	// data accesses reach the core
	property p_push;
		@(posedge clk) disable iff (!rstN)
		(ce && fifoPush && fifoInReady) |=> regWrValid;
	endproperty
	a_push: assert property (p_push) else $error("data write lost");
	property p_rdData;
		@(posedge clk) disable iff (!rstN)
		(ce && regRdStrobe) |=> hostDataOut == $past(regRdData);
	endproperty
	a_rdData: assert property (p_rdData) else $error("data read wrong");
	property p_refused;
		@(posedge clk) disable iff (!rstN)
		(ce && fifoPush && !fifoInReady && !hostRd) |=> $stable(ptr_q);
	endproperty
	a_refused: assert property (p_refused) else $error("pointer moved");
	property p_errSet;
		@(posedge clk) disable iff (!rstN)
		((|errorBits) && !errMask_q) |-> status[dhp_pkg::ST_ERR];
	endproperty
	a_errSet: assert property (p_errSet) else $error("error hidden");
	property p_incrBusy;
		@(posedge clk) disable iff (!rstN)
		(state_q == dhp_pkg::INCR) |-> status[dhp_pkg::ST_BUSY];
	endproperty
	a_incrBusy: assert property (p_incrBusy) else $error("incr not busy");
	// a low enable holds pointer, sequencer and read data
	property p_freeze;
		@(posedge clk) disable iff (!rstN)
		!ce |=> $stable(ptr_q) && $stable(state_q) && $stable(hostDataOut);
	endproperty
	a_freeze: assert property (p_freeze) else $error("state moved");
	c_incr: cover property (@(posedge clk) disable iff (!rstN) ce && advance);
	c_full: cover property (@(posedge clk) disable iff (!rstN) !fifoInReady);
	c_clr: cover property (@(posedge clk) disable iff (!rstN)
		errMask_q && (|errorBits));
	c_step: cover property (@(posedge clk) disable iff (!rstN)
		ce && fifoPush && ptr_q[5:0] == dhp_pkg::REG_STEP);
	c_phase: cover property (@(posedge clk) disable iff (!rstN)
		speedUpRequest || slowDownRequest);
endmodule : dhp_host_port
`default_nettype wire

//--- verilog/dhp_pkg.sv
// constants and types shared by the disk controller host port
// What this block does
// - select low: write loads pointer byte, read returns status
// - auto-increment set: pointer advances by one after each register access
// - no advance after writing the step control register
// - no advance after any access to the disk data register
// - status bit 7 busy: disk op, byte processing or pointer increment
// - status bit 6 high while a disk operation runs
// - status bit 5 mirrors the write gate output
// - status bit 4 asks host to write a disk data byte
// - status bit 3 says a disk data byte waits to be read
// - status bit 1 follows the track zero pin
// - status bit 0 is the OR of the error register bits
// - writing the disk operation register clears the error summary
// - slow_down_request and speed_up_request outputs steer the external oscillator
package dhp_pkg;
	localparam logic [7:0] PTR_RESET = 8'h00;
	localparam int PTR_INC_BIT = 7;
	localparam int PTR_DATA_BIT = 6;
	localparam logic [5:0] REG_STEP = 6'h1F;
	localparam logic [5:0] REG_DISK_OP = 6'h3F;
	localparam int ST_BUSY = 7;
	localparam int ST_OP = 6;
	localparam int ST_WGATE = 5;
	localparam int ST_DREQ = 4;
	localparam int ST_DAVAIL = 3;
	localparam int ST_SEEK = 2;
	localparam int ST_TRK0 = 1;
	localparam int ST_ERR = 0;
	localparam int FIFO_DEPTH = 16;
	localparam int SYNC_STAGES = 3;
	typedef struct packed {
		logic [7:0] data;
		logic [5:0] addr;
	} dhp_wr_type;
	typedef enum logic [1:0] {
		IDLE,
		BUSY,
		INCR
	} dhp_state_type;
endpackage : dhp_pkg
